// [verilog/atutm_timer.sv]
// asynchronous 8-bit timer: update-busy handshake, flags, masks, prescaler
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - control write in async mode sets busy
// - counter read returns live count
// - compare/control read returns temporary copy
// - compare irq = enable, global, flag
// - overflow irq = enable, global, flag
// - counter equals compare sets compare flag
// - vector or write-one clears compare flag
// - overflow sets overflow flag
// - vector or write-one clears overflow flag
// - phase pwm overflow flag at reversal at bottom
// - prescaler reset bit self-clears
// - prescaler reset reads zero when synchronous
// - async prescaler reset reads one until done
// - io offsets, data space adds 0x20
// - select bit picks io or oscillator clock
// - count/compare write in async sets busy
module atutm_timer (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [atutm_pkg::ADDR_W-1:0] IO_ADDR,
    input wire logic IO_DATA_SPACE,
    input wire logic IO_WE,
    input wire logic IO_RE,
    input wire logic [atutm_pkg::DATA_W-1:0] IO_WDATA,
    output logic [atutm_pkg::DATA_W-1:0] IO_RDATA,
    input wire logic TOSC_PIN,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic COMPARE_VECTOR_DONE,
    input wire logic OVERFLOW_VECTOR_DONE,
    output logic COMPARE_IRQ,
    output logic OVERFLOW_IRQ
);
    import atutm_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] count;
        logic [DATA_W-1:0] count_tmp;
        logic [DATA_W-1:0] compare;
        logic [DATA_W-1:0] compare_tmp;
        logic [DATA_W-1:0] control;
        logic [DATA_W-1:0] control_tmp;
        logic count_busy;
        logic compare_busy;
        logic control_busy;
        logic async_sel;
        logic compare_flag;
        logic overflow_flag;
        logic compare_ie;
        logic overflow_ie;
        logic presc_pending;
        logic count_down;
        logic match_block;
        logic [PRESC_W-1:0] presc;
        logic [DATA_W-1:0] rdata;
    } atutm_state_t;

    atutm_state_t s;
    atutm_state_t next_s;

    atutm_tick_if osc_tick ();

    atutm_osc_sync u_osc_sync (
        .clk(CLK),
        .rst(RST),
        .osc_pin(TOSC_PIN),
        .tk(osc_tick)
    );

    // io index of an access, with a valid bit on top
    function automatic logic [IDX_W:0] reg_index(
        input logic [ADDR_W-1:0] addr,
        input logic dspace
    );
        logic [ADDR_W-1:0] shifted;
        shifted = addr - DATA_SPACE_OFS;
        if (dspace) begin
            reg_index = {(addr >= DATA_SPACE_OFS) && (addr < DATA_SPACE_END),
                         shifted[IDX_W-1:0]};
        end else begin
            reg_index = {addr < IO_SPACE_END, addr[IDX_W-1:0]};
        end
    endfunction

    function automatic atutm_mode_t mode_of(input logic [DATA_W-1:0] ctl);
        unique case ({ctl[BIT_WGM_HIGH], ctl[BIT_WGM_LOW]})
            2'b00: mode_of = MODE_NORMAL;
            2'b01: mode_of = MODE_PHASE_PWM;
            2'b10: mode_of = MODE_CTC;
            2'b11: mode_of = MODE_FAST_PWM;
        endcase
    endfunction

    function automatic logic [CS_W-1:0] clock_sel(
        input logic [DATA_W-1:0] ctl
    );
        clock_sel = ctl[CS_LSB +: CS_W];
    endfunction

    logic [IDX_W:0] acc;
    logic acc_ok;
    logic wr;
    logic src_tick;
    logic timer_tick;
    logic xfer_tick;
    logic match;
    logic [CS_W-1:0] cs;
    logic [PRESC_W-1:0] tap;
    atutm_mode_t mode;
    logic set_ocf;
    logic set_tov;
    logic clr_ocf;
    logic clr_tov;
    logic [DATA_W-1:0] rd;

    always_comb begin
        next_s = s;
        acc = reg_index(IO_ADDR, IO_DATA_SPACE);
        acc_ok = acc[IDX_W];
        wr = IO_WE && acc_ok;
        cs = clock_sel(s.control);
        mode = mode_of(s.control);
        tap = PRESC_MASK[cs];
        set_ocf = 1'b0;
        set_tov = 1'b0;
        clr_ocf = COMPARE_VECTOR_DONE;
        clr_tov = OVERFLOW_VECTOR_DONE;
        rd = RST_REG;

        // timer domain: oscillator edges or every io clock
        src_tick = s.async_sel ? osc_tick.tick : 1'b1;
        xfer_tick = s.async_sel && osc_tick.tick;
        timer_tick = src_tick && (cs != CS_STOPPED)
                     && ((s.presc & tap) == tap);
        match = (s.count == s.compare) && !s.match_block;

        if (src_tick) begin
            next_s.presc = s.presc + PRESC_STEP;
        end

        if (timer_tick) begin
            next_s.match_block = 1'b0;
            if (match) begin
                set_ocf = 1'b1;
            end
            unique case (mode)
                MODE_NORMAL, MODE_FAST_PWM: begin
                    next_s.count = s.count + COUNT_STEP;
                    if (s.count == COUNT_MAX) begin
                        set_tov = 1'b1;
                    end
                end
                MODE_CTC: begin
                    if (match) begin
                        next_s.count = COUNT_BOTTOM;
                    end else begin
                        next_s.count = s.count + COUNT_STEP;
                    end
                    if (s.count == COUNT_MAX) begin
                        set_tov = 1'b1;
                    end
                end
                MODE_PHASE_PWM: begin
                    if (s.count_down && s.count == COUNT_BOTTOM) begin
                        // turn upward at bottom, overflow here only
                        next_s.count_down = 1'b0;
                        next_s.count = s.count + COUNT_STEP;
                        set_tov = 1'b1;
                    end else if (!s.count_down && s.count == COUNT_MAX) begin
                        next_s.count_down = 1'b1;
                        next_s.count = s.count - COUNT_STEP;
                    end else if (s.count_down) begin
                        next_s.count = s.count - COUNT_STEP;
                    end else begin
                        next_s.count = s.count + COUNT_STEP;
                    end
                end
            endcase
        end

        // temporary storage lands on the oscillator edge
        if (xfer_tick) begin
            if (s.count_busy) begin
                next_s.count = s.count_tmp;
                next_s.match_block = 1'b1;
                next_s.count_busy = 1'b0;
            end
            if (s.compare_busy) begin
                next_s.compare = s.compare_tmp;
                next_s.compare_busy = 1'b0;
            end
            if (s.control_busy) begin
                next_s.control = s.control_tmp;
                next_s.control_busy = 1'b0;
            end
            if (s.presc_pending) begin
                next_s.presc = PRESC_CLEAR;
                next_s.presc_pending = 1'b0;
            end
        end

        // cpu writes; a write here overrides count and transfer
        // busy is not checked: writing while busy is the caller's risk
        if (wr) begin
            unique case (acc[IDX_W-1:0])
                OFS_TIMER_COUNT: begin
                    if (s.async_sel) begin
                        next_s.count_tmp = IO_WDATA;
                        next_s.count_busy = 1'b1;
                    end else begin
                        next_s.count = IO_WDATA;
                        next_s.count_tmp = IO_WDATA;
                        next_s.match_block = 1'b1;
                    end
                end
                OFS_TIMER_COMPARE: begin
                    next_s.compare_tmp = IO_WDATA;
                    if (s.async_sel) begin
                        next_s.compare_busy = 1'b1;
                    end else begin
                        next_s.compare = IO_WDATA;
                    end
                end
                OFS_TIMER_CONTROL: begin
                    next_s.control_tmp = IO_WDATA;
                    if (s.async_sel) begin
                        next_s.control_busy = 1'b1;
                    end else begin
                        next_s.control = IO_WDATA;
                    end
                end
                OFS_ASYNC_STATUS: begin
                    // switching source may corrupt timer contents
                    next_s.async_sel = IO_WDATA[BIT_ASYNC_SEL];
                end
                OFS_IRQ_MASK: begin
                    next_s.compare_ie = IO_WDATA[BIT_COMPARE_IE];
                    next_s.overflow_ie = IO_WDATA[BIT_OVERFLOW_IE];
                end
                OFS_IRQ_FLAGS: begin
                    // write one clears, zero leaves
                    clr_ocf = clr_ocf || IO_WDATA[BIT_COMPARE_FLAG];
                    clr_tov = clr_tov || IO_WDATA[BIT_OVERFLOW_FLAG];
                end
                OFS_SPECIAL_FUNC: begin
                    if (IO_WDATA[BIT_PRESC_RESET]) begin
                        if (s.async_sel) begin
                            next_s.presc_pending = 1'b1;
                        end else begin
                            next_s.presc = PRESC_CLEAR;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // a hardware set in the clearing cycle wins
        if (clr_ocf) begin
            next_s.compare_flag = 1'b0;
        end
        if (set_ocf) begin
            next_s.compare_flag = 1'b1;
        end
        if (clr_tov) begin
            next_s.overflow_flag = 1'b0;
        end
        if (set_tov) begin
            next_s.overflow_flag = 1'b1;
        end

        // read path, bits of other timers read zero
        if (acc_ok) begin
            unique case (acc[IDX_W-1:0])
                OFS_TIMER_COUNT: begin
                    rd = s.count;
                end
                OFS_TIMER_COMPARE: begin
                    rd = s.compare_tmp;
                end
                OFS_TIMER_CONTROL: begin
                    rd = s.control_tmp;
                end
                OFS_ASYNC_STATUS: begin
                    rd[BIT_ASYNC_SEL] = s.async_sel;
                    rd[BIT_COUNT_BUSY] = s.count_busy;
                    rd[BIT_COMPARE_BUSY] = s.compare_busy;
                    rd[BIT_CTRL_BUSY] = s.control_busy;
                end
                OFS_IRQ_MASK: begin
                    rd[BIT_COMPARE_IE] = s.compare_ie;
                    rd[BIT_OVERFLOW_IE] = s.overflow_ie;
                end
                OFS_IRQ_FLAGS: begin
                    rd[BIT_COMPARE_FLAG] = s.compare_flag;
                    rd[BIT_OVERFLOW_FLAG] = s.overflow_flag;
                end
                OFS_SPECIAL_FUNC: begin
                    // zero when clocked from the io clock
                    rd[BIT_PRESC_RESET] = s.async_sel && s.presc_pending;
                end
                default: begin
                    rd = RST_REG;
                end
            endcase
        end
        if (IO_RE) begin
            next_s.rdata = rd;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s <= '{
                count: RST_REG,
                count_tmp: RST_REG,
                compare: RST_REG,
                compare_tmp: RST_REG,
                control: RST_REG,
                control_tmp: RST_REG,
                count_busy: 1'b0,
                compare_busy: 1'b0,
                control_busy: 1'b0,
                async_sel: 1'b0,
                compare_flag: 1'b0,
                overflow_flag: 1'b0,
                compare_ie: 1'b0,
                overflow_ie: 1'b0,
                presc_pending: 1'b0,
                count_down: 1'b0,
                match_block: 1'b0,
                presc: PRESC_CLEAR,
                rdata: RST_REG
            };
        end else begin
            s <= next_s;
        end
    end

    assign IO_RDATA = s.rdata;
    assign COMPARE_IRQ = s.compare_ie && GLOBAL_IRQ_EN
                         && s.compare_flag;
    assign OVERFLOW_IRQ = s.overflow_ie && GLOBAL_IRQ_EN
                          && s.overflow_flag;
endmodule // atutm_timer
`default_nettype wire

// [verilog/atutm_pkg.sv]
// constants and types shared by the asynchronous timer block
package atutm_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int IDX_W = 6;
    localparam int PRESC_W = 10;
    localparam int CS_W = 3;

    // data-space view sits this far above the io-space view
    localparam logic [ADDR_W-1:0] DATA_SPACE_OFS = 7'h20;
    localparam logic [ADDR_W-1:0] DATA_SPACE_END = 7'h60;
    localparam logic [ADDR_W-1:0] IO_SPACE_END = 7'h40;

    localparam logic [IDX_W-1:0] OFS_SPECIAL_FUNC = 6'h30;
    localparam logic [IDX_W-1:0] OFS_IRQ_FLAGS = 6'h38;
    localparam logic [IDX_W-1:0] OFS_IRQ_MASK = 6'h39;
    localparam logic [IDX_W-1:0] OFS_ASYNC_STATUS = 6'h22;
    localparam logic [IDX_W-1:0] OFS_TIMER_CONTROL = 6'h25;
    localparam logic [IDX_W-1:0] OFS_TIMER_COUNT = 6'h26;
    localparam logic [IDX_W-1:0] OFS_TIMER_COMPARE = 6'h27;

    localparam int BIT_COMPARE_IE = 7;
    localparam int BIT_OVERFLOW_IE = 6;
    localparam int BIT_COMPARE_FLAG = 7;
    localparam int BIT_OVERFLOW_FLAG = 6;
    localparam int BIT_PRESC_RESET = 1;
    localparam int BIT_ASYNC_SEL = 3;
    localparam int BIT_COUNT_BUSY = 2;
    localparam int BIT_COMPARE_BUSY = 1;
    localparam int BIT_CTRL_BUSY = 0;
    localparam int BIT_WGM_LOW = 6;
    localparam int BIT_WGM_HIGH = 3;
    localparam int CS_LSB = 0;

    localparam logic [DATA_W-1:0] RST_REG = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_BOTTOM = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;
    localparam logic [DATA_W-1:0] COUNT_STEP = 8'h01;
    localparam logic [PRESC_W-1:0] PRESC_STEP = 10'h001;
    localparam logic [PRESC_W-1:0] PRESC_CLEAR = 10'h000;
    localparam logic [CS_W-1:0] CS_STOPPED = 3'h0;

    // prescaler taps for clock select 0..7: stop, 1, 8, 32, 64, 128, 256, 1024
    localparam logic [PRESC_W-1:0] PRESC_MASK [0:7] = '{
        10'h000, 10'h000, 10'h007, 10'h01F,
        10'h03F, 10'h07F, 10'h0FF, 10'h3FF
    };

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PHASE_PWM,
        MODE_CTC,
        MODE_FAST_PWM
    } atutm_mode_t;
endpackage

// [verilog/atutm_tick_if.sv]
// carries the synchronised oscillator tick between the timer modules
`timescale 1ns/1ns
`default_nettype none
interface atutm_tick_if;
    logic tick;
    modport drv (output tick);
    modport use_side (input tick);
endinterface
`default_nettype wire

// [verilog/atutm_osc_sync.sv]
// oscillator pin synchroniser and rising edge tick
`timescale 1ns/1ns
`default_nettype none
module atutm_osc_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_pin,
    atutm_tick_if.drv tk
);
    import atutm_pkg::*;

    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
    } atutm_sync_t;

    atutm_sync_t s;
    atutm_sync_t next_s;

    always_comb begin
        next_s = s;
        next_s.meta = osc_pin;
        next_s.stable = s.meta;
        next_s.prev = s.stable;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // one-cycle pulse per oscillator rising edge
    assign tk.tick = s.stable & ~s.prev;
endmodule // atutm_osc_sync
`default_nettype wire

// [sim/atutm_timer_assertions.sv]
// port-level assertion checker for the asynchronous timer
`timescale 1ns/1ns
`default_nettype none
module atutm_assertions
    import atutm_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [atutm_pkg::ADDR_W-1:0] IO_ADDR,
    input wire logic IO_DATA_SPACE,
    input wire logic IO_WE,
    input wire logic IO_RE,
    input wire logic [atutm_pkg::DATA_W-1:0] IO_WDATA,
    input wire logic [atutm_pkg::DATA_W-1:0] IO_RDATA,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic COMPARE_IRQ,
    input wire logic OVERFLOW_IRQ
);
    logic [IDX_W-1:0] ix;
    logic ok;
    logic mapped;
    logic [DATA_W-1:0] m;
    logic as_sel;
    logic [DATA_W-1:0] cmp_w;
    logic [DATA_W-1:0] ctl_w;

    always_comb begin
        ix = IO_ADDR[5:0] - (IO_DATA_SPACE ? 6'h20 : 6'h00);
        ok = IO_DATA_SPACE ? (IO_ADDR >= 7'h20 && IO_ADDR < 7'h60)
                           : !IO_ADDR[6];
        mapped = ok && ix inside {OFS_SPECIAL_FUNC, OFS_IRQ_FLAGS,
            OFS_IRQ_MASK, OFS_ASYNC_STATUS, OFS_TIMER_CONTROL,
            OFS_TIMER_COUNT, OFS_TIMER_COMPARE};
    end

    function automatic logic hit(input logic [IDX_W-1:0] o);
        hit = IO_RE && ok && ix == o;
    endfunction

    function automatic logic wrh(input logic [IDX_W-1:0] o);
        wrh = IO_WE && ok && ix == o;
    endfunction

    // shadow of the cpu-only mask and clock select bits
    always_ff @(posedge CLK) begin
        if (RST) begin
            m <= 8'h00;
            as_sel <= 1'b0;
            cmp_w <= 8'h00;
            ctl_w <= 8'h00;
        end else begin
            if (wrh(OFS_IRQ_MASK))
                m <= IO_WDATA & 8'hC0;
            // last written values, which reads must return at once
            if (wrh(OFS_TIMER_COMPARE))
                cmp_w <= IO_WDATA;
            if (wrh(OFS_TIMER_CONTROL))
                ctl_w <= IO_WDATA;
            if (wrh(OFS_ASYNC_STATUS))
                as_sel <= IO_WDATA[BIT_ASYNC_SEL];
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    reset_clear_a: assert property ($fell(RST) |->
        IO_RDATA == RST_REG && !COMPARE_IRQ && !OVERFLOW_IRQ)
        else $error("outputs not clear after reset");
    unmapped_zero_a: assert property (IO_RE && !mapped |=>
        IO_RDATA == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!IO_RE |=> $stable(IO_RDATA))
        else $error("read data moved without a read");
    mask_read_a: assert property (hit(OFS_IRQ_MASK) |=>
        IO_RDATA == $past(m)) else $error("mask read mismatch");
    flags_unused_a: assert property (hit(OFS_IRQ_FLAGS) |=>
        IO_RDATA[5:0] == 6'h00) else $error("foreign flag bits set");
    presc_sync_a: assert property (hit(OFS_SPECIAL_FUNC) &&
        !as_sel |=> IO_RDATA == 8'h00)
        else $error("prescaler reset bit read in sync mode");
    compare_temp_a: assert property (hit(OFS_TIMER_COMPARE) |=>
        IO_RDATA == $past(cmp_w))
        else $error("compare read not temp copy");
    control_temp_a: assert property (hit(OFS_TIMER_CONTROL) |=>
        IO_RDATA == $past(ctl_w))
        else $error("control read not temp copy");
    cmp_irq_gate_a: assert property (COMPARE_IRQ |->
        GLOBAL_IRQ_EN && m[BIT_COMPARE_IE])
        else $error("compare irq without enables");
    ovf_irq_gate_a: assert property (OVERFLOW_IRQ |->
        GLOBAL_IRQ_EN && m[BIT_OVERFLOW_IE])
        else $error("overflow irq without enables");
endmodule // atutm_assertions

bind atutm_timer atutm_assertions chk (
    .CLK(CLK),
    .RST(RST),
    .IO_ADDR(IO_ADDR),
    .IO_DATA_SPACE(IO_DATA_SPACE),
    .IO_WE(IO_WE),
    .IO_RE(IO_RE),
    .IO_WDATA(IO_WDATA),
    .IO_RDATA(IO_RDATA),
    .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
    .COMPARE_IRQ(COMPARE_IRQ),
    .OVERFLOW_IRQ(OVERFLOW_IRQ)
);
`default_nettype wire

// [sim/atutm_timer_tb.sv]
// self-checking bench for the asynchronous timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module atutm_timer_tb;
    import atutm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = 7'h00;
    logic dsp = 1'b0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic [DATA_W-1:0] rdata;
    logic tosc = 1'b0;
    logic gie = 1'b0;
    logic cvd = 1'b0;
    logic ovd = 1'b0;
    logic cirq;
    logic oirq;
    logic [DATA_W-1:0] v;
    int n_mismatch = 0;
    int checked = 0;

    atutm_timer dut (
        .CLK(clk),
        .RST(rst),
        .IO_ADDR(addr),
        .IO_DATA_SPACE(dsp),
        .IO_WE(we),
        .IO_RE(re),
        .IO_WDATA(wdata),
        .IO_RDATA(rdata),
        .TOSC_PIN(tosc),
        .GLOBAL_IRQ_EN(gie),
        .COMPARE_VECTOR_DONE(cvd),
        .OVERFLOW_VECTOR_DONE(ovd),
        .COMPARE_IRQ(cirq),
        .OVERFLOW_IRQ(oirq)
    );

    always #2 clk = ~clk;

    task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
        @(negedge clk);
        addr = {1'b0, i} + (dsp ? 7'h20 : 7'h00);
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask

    task automatic rd(input logic [IDX_W-1:0] i, output logic [7:0] d);
        @(negedge clk);
        addr = {1'b0, i} + (dsp ? 7'h20 : 7'h00);
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        d = rdata;
    endtask

    task automatic chk_rd(input logic [IDX_W-1:0] i, input logic [7:0] e);
        logic [7:0] d;
        rd(i, d);
        `CHK(d, e)
    endtask

    task automatic do_rst;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
    endtask

    // one oscillator period, each level held four cycles
    task automatic osc_pulse;
        tosc = 1'b1;
        repeat (4) @(negedge clk);
        tosc = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    task automatic t_reset;
        logic [IDX_W-1:0] offs [7] = '{OFS_SPECIAL_FUNC, OFS_IRQ_FLAGS,
            OFS_IRQ_MASK, OFS_ASYNC_STATUS, OFS_TIMER_CONTROL,
            OFS_TIMER_COUNT, OFS_TIMER_COMPARE};
        foreach (offs[k])
            chk_rd(offs[k], RST_REG);
        $display("test reset values done");
    endtask

    task automatic t_space;
        wr(OFS_IRQ_MASK, 8'hFF);
        dsp = 1'b1;
        chk_rd(OFS_IRQ_MASK, 8'hC0);
        wr(OFS_IRQ_MASK, 8'h00);
        dsp = 1'b0;
        chk_rd(OFS_IRQ_MASK, 8'h00);
        chk_rd(6'h3F, 8'h00);
        $display("test address spaces done");
    endtask

    task automatic t_flags;
        wr(OFS_TIMER_COUNT, 8'hFD);
        wr(OFS_TIMER_CONTROL, 8'h01);
        repeat (8) @(negedge clk);
        wr(OFS_TIMER_CONTROL, 8'h00);
        chk_rd(OFS_IRQ_FLAGS, 8'hC0);
        wr(OFS_IRQ_MASK, 8'hC0);
        `CHK({cirq, oirq}, 2'b00)
        gie = 1'b1;
        @(negedge clk);
        `CHK({cirq, oirq}, 2'b11)
        cvd = 1'b1;
        @(negedge clk);
        cvd = 1'b0;
        @(negedge clk);
        `CHK({cirq, oirq}, 2'b01)
        wr(OFS_IRQ_FLAGS, 8'h00);
        chk_rd(OFS_IRQ_FLAGS, 8'h40);
        wr(OFS_IRQ_FLAGS, 8'h40);
        chk_rd(OFS_IRQ_FLAGS, 8'h00);
        `CHK(oirq, 1'b0)
        gie = 1'b0;
        wr(OFS_IRQ_MASK, 8'h00);
        $display("test flags and irqs done");
    endtask

    task automatic t_pwm;
        do_rst();
        wr(OFS_TIMER_CONTROL, 8'h41);
        repeat (200) @(negedge clk);
        wr(OFS_IRQ_FLAGS, 8'hC0);
        repeat (90) @(negedge clk);
        rd(OFS_IRQ_FLAGS, v);
        `CHK(v[BIT_OVERFLOW_FLAG], 1'b0)
        repeat (300) @(negedge clk);
        rd(OFS_IRQ_FLAGS, v);
        `CHK(v[BIT_OVERFLOW_FLAG], 1'b1)
        wr(OFS_TIMER_CONTROL, 8'h00);
        $display("test phase pwm overflow done");
    endtask

    // ctc clears on match, fast pwm overflows at wrap
    task automatic t_modes;
        wr(OFS_TIMER_COMPARE, 8'h03);
        wr(OFS_TIMER_COUNT, 8'h00);
        wr(OFS_IRQ_FLAGS, 8'hC0);
        wr(OFS_TIMER_CONTROL, 8'h09);
        repeat (20) @(negedge clk);
        wr(OFS_TIMER_CONTROL, 8'h00);
        chk_rd(OFS_IRQ_FLAGS, 8'h80);
        chk_rd(OFS_TIMER_COUNT, 8'h02);
        wr(OFS_TIMER_COUNT, 8'hFD);
        wr(OFS_IRQ_FLAGS, 8'hC0);
        wr(OFS_TIMER_CONTROL, 8'h49);
        repeat (8) @(negedge clk);
        wr(OFS_TIMER_CONTROL, 8'h00);
        chk_rd(OFS_IRQ_FLAGS, 8'hC0);
        chk_rd(OFS_TIMER_COUNT, 8'h07);
        ovd = 1'b1;
        @(negedge clk);
        ovd = 1'b0;
        chk_rd(OFS_IRQ_FLAGS, 8'h80);
        $display("test ctc and fast pwm done");
    endtask

    task automatic t_async;
        do_rst();
        wr(OFS_ASYNC_STATUS, 8'h08);
        wr(OFS_TIMER_COMPARE, 8'h55);
        wr(OFS_TIMER_CONTROL, 8'h02);
        wr(OFS_TIMER_COUNT, 8'h10);
        chk_rd(OFS_ASYNC_STATUS, 8'h0F);
        chk_rd(OFS_TIMER_COMPARE, 8'h55);
        chk_rd(OFS_TIMER_CONTROL, 8'h02);
        chk_rd(OFS_TIMER_COUNT, 8'h00);
        wr(OFS_SPECIAL_FUNC, 8'h02);
        chk_rd(OFS_SPECIAL_FUNC, 8'h02);
        osc_pulse();
        chk_rd(OFS_ASYNC_STATUS, 8'h08);
        chk_rd(OFS_TIMER_COUNT, 8'h10);
        chk_rd(OFS_SPECIAL_FUNC, 8'h00);
        wr(OFS_TIMER_COUNT, 8'h20);
        chk_rd(OFS_ASYNC_STATUS, 8'h0C);
        osc_pulse();
        chk_rd(OFS_ASYNC_STATUS, 8'h08);
        wr(OFS_ASYNC_STATUS, 8'h00);
        wr(OFS_SPECIAL_FUNC, 8'h02);
        chk_rd(OFS_SPECIAL_FUNC, 8'h00);
        $display("test async handshake done");
    endtask

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_space();
        t_flags();
        t_pwm();
        t_modes();
        t_async();
        give_verdict();
    end

    // run needs about 780 cycles
    initial begin
        #20_000;
        n_mismatch++;
        give_verdict();
    end
endmodule // atutm_timer_tb
`default_nettype wire
